/* File: verilog/msc_pkg.sv */
// Behaviour
// R1 - unlock register is write only; reads return zero
// R2 - write 5x then Ax to the unlock register arms the gate
// R3 - stop request while armed enters STOP; oscillators, cpu, peripherals halt
// R4 - entering STOP disarms the unlock gate
// R5 - other activity between the two unlock writes does not break arming
// R6 - any unlock write other than Ax after 5x cancels the first step; here a repeated 5x write keeps the first step
// R7 - gate held disarmed during system reset
// R8 - gate refuses to arm while any enabled interrupt is pending
// R9 - in STOP, nmi or enabled port-0 pin interrupt clears stop, resumes run
// R10 - writing one to halt bit 0 stops cpu, peripherals keep running
// R11 - in HALT, nmi, watchdog or enabled interrupt ends HALT
// R12 - standby bits: stop at 1, halt at 0; 00 run, 01 halt, 10 stop
// R13 - HALT or STOP request ignored while any enabled interrupt is pending
// R14 - maskable wake with master enable clear releases mode without servicing
// R15 - block_disable_0 bits 3..0 hold timer channels in reset, clock off
// R16 - block_disable_1 bit 0 holds pwm in reset, clock off
// R17 - while disabled, peripheral registers held at reset and clock stopped
// R18 - while disabled, peripheral writes ignored and reads give initial values
// R19 - software clears a block-disable bit before using that peripheral
// R20 - halt bit cleared at the next system clock after a halt wake
// R21 - writing both stop and halt together changes nothing, stays in run
package msc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [15:0] MSC_STOP_UNLOCK_OFS     = 16'hf008;
  localparam logic [15:0] MSC_STANDBY_CONTROL_OFS = 16'hf009;
  localparam logic [15:0] MSC_BLOCK_DISABLE_0_OFS = 16'hf028;
  localparam logic [15:0] MSC_BLOCK_DISABLE_1_OFS = 16'hf029;
  localparam logic [15:0] MSC_BLOCK_DISABLE_2_OFS = 16'hf02a;
  localparam logic [15:0] MSC_BLOCK_DISABLE_3_OFS = 16'hf02b;
  localparam logic [15:0] MSC_BLOCK_DISABLE_4_OFS = 16'hf02c;
  localparam logic [15:0] MSC_MODE_STATUS_OFS     = 16'hf030;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          MSC_HALT_BIT       = 0;
  localparam int          MSC_STOP_BIT       = 1;
  localparam logic [3:0]  MSC_UNLOCK_FIRST   = 4'h5;
  localparam logic [3:0]  MSC_UNLOCK_SECOND  = 4'ha;
  localparam logic [7:0]  MSC_BLOCK_RESET    = 8'h00;
  localparam logic [1:0]  MSC_STANDBY_RESET  = 2'h0;
  localparam int          MSC_NUM_TIMERS     = 4;
  localparam int          MSC_NUM_IRQ        = 16;
  localparam int          MSC_NUM_PIN_IRQ    = 4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0]
  {
    MSC_RUN  = 2'b00,
    MSC_HALT = 2'b01,
    MSC_STOP = 2'b10
  } msc_mode_type;

  typedef enum logic [1:0]
  {
    MSC_UL_IDLE  = 2'b00,
    MSC_UL_FIRST = 2'b01,
    MSC_UL_ARMED = 2'b10
  } msc_unlock_type;

endpackage

/* File: verilog/msc_standby_ctrl.sv */
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module msc_standby_ctrl
  import msc_pkg::*;
(
  // clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  // apb slave
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [15:0]                i_paddr,
  input  wire logic [31:0]                i_pwdata,
  input  wire logic [3:0]                 i_pstrb,
  output logic      [31:0]                o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  // interrupt sources
  input  wire logic [MSC_NUM_IRQ-1:0]     i_irq_enable,
  input  wire logic [MSC_NUM_IRQ-1:0]     i_irq_request,
  input  wire logic                       i_nmi_request,
  input  wire logic                       i_wdt_request,
  input  wire logic                       i_master_irq_enable,
  // mode outputs
  output logic                            o_cpu_halt,
  output logic                            o_osc_stop,
  output logic                            o_periph_stop,
  output logic                            o_wake_no_service,
  // gated peripherals
  output logic [MSC_NUM_TIMERS-1:0]       o_timer_rst,
  output logic [MSC_NUM_TIMERS-1:0]       o_timer_clk_en,
  output logic [MSC_NUM_TIMERS-1:0]       o_timer_wr_block,
  output logic                            o_pwm_rst,
  output logic                            o_pwm_clk_en,
  output logic                            o_pwm_wr_block,
  output logic [7:0]                      o_block_disable_2,
  output logic [7:0]                      o_block_disable_3,
  output logic [7:0]                      o_block_disable_4
);

  // ****************************************
  // bus decode
  // ****************************************
  msc_mode_type   mode_q;
  msc_mode_type   mode_d;
  msc_unlock_type unlock_q;
  msc_unlock_type unlock_d;
  logic [7:0]     blk0_q;
  logic [7:0]     blk1_q;
  logic [7:0]     blk2_q;
  logic [7:0]     blk3_q;
  logic [7:0]     blk4_q;
  logic           wake_ns_q;

  // pslverr stays low: unmapped reads give zero, unmapped writes are dropped
  wire        wr_en     = i_psel & i_penable & i_pwrite & i_pstrb[0];
  // read data loads in the setup cycle so it already stands at the access edge
  wire        rd_setup  = i_psel & ~i_penable & ~i_pwrite;
  wire        sel_ul    = (i_paddr == MSC_STOP_UNLOCK_OFS);
  wire        sel_sby   = (i_paddr == MSC_STANDBY_CONTROL_OFS);
  wire        sel_b0    = (i_paddr == MSC_BLOCK_DISABLE_0_OFS);
  wire        sel_b1    = (i_paddr == MSC_BLOCK_DISABLE_1_OFS);
  wire        sel_b2    = (i_paddr == MSC_BLOCK_DISABLE_2_OFS);
  wire        sel_b3    = (i_paddr == MSC_BLOCK_DISABLE_3_OFS);
  wire        sel_b4    = (i_paddr == MSC_BLOCK_DISABLE_4_OFS);
  wire        sel_st    = (i_paddr == MSC_MODE_STATUS_OFS);
  wire [7:0]  wbyte     = i_pwdata[7:0];
  wire        wr_ul     = wr_en & sel_ul;
  wire        wr_sby    = wr_en & sel_sby;
  wire [7:0]  status    = {4'h0, wake_ns_q, (unlock_q == MSC_UL_ARMED), mode_q};
  wire [7:0]  rd_byte;

  // R1 unlock reads zero
  assign rd_byte = sel_ul  ? 8'h00 :
                   sel_sby ? 8'h00 :
                   sel_b0  ? blk0_q :
                   sel_b1  ? blk1_q :
                   sel_b2  ? blk2_q :
                   sel_b3  ? blk3_q :
                   sel_b4  ? blk4_q :
                   sel_st  ? status : 8'h00;

  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;

  // ****************************************
  // interrupt qualification
  // ****************************************
  // R8 pending enabled irq
  wire pend_any = |(i_irq_enable & i_irq_request);
  wire pin_wake = |(i_irq_enable[MSC_NUM_PIN_IRQ-1:0] & i_irq_request[MSC_NUM_PIN_IRQ-1:0]);
  // R9 stop wake sources
  wire stop_wake = i_nmi_request | pin_wake;
  // R11 halt wake sources
  wire halt_wake = i_nmi_request | i_wdt_request | pend_any;

  // ****************************************
  // unlock gate
  // ****************************************
  wire [3:0] ul_nib = wbyte[7:4];
  wire       enter_stop;

  always_comb
  begin
    unlock_d = unlock_q;
    // R4 stop entry disarms
    if (enter_stop)
    begin
      unlock_d = MSC_UL_IDLE;
    end
    else if (wr_ul)
    begin
      case (unlock_q)
        // R2 first step
        MSC_UL_IDLE:
          unlock_d = (ul_nib == MSC_UNLOCK_FIRST) ? MSC_UL_FIRST : MSC_UL_IDLE;
        // R6 wrong second write cancels, a repeated 5x keeps the first step; R8 pending irq blocks arming
        MSC_UL_FIRST:
          if (ul_nib == MSC_UNLOCK_SECOND && !pend_any)
            unlock_d = MSC_UL_ARMED;
          else if (ul_nib == MSC_UNLOCK_FIRST)
            unlock_d = MSC_UL_FIRST;
          else
            unlock_d = MSC_UL_IDLE;
        default:
          unlock_d = MSC_UL_ARMED;
      endcase
    end
    // R5 other traffic keeps state
  end

  // ****************************************
  // standby mode
  // ****************************************
  // R12 stop and halt bits
  wire       stop_bit = wbyte[MSC_STOP_BIT];
  wire       halt_bit = wbyte[MSC_HALT_BIT];
  // R21 both bits is a no-op; R13 pending irq blocks entry
  wire       req_halt = wr_sby & halt_bit & ~stop_bit & ~pend_any;
  // R3 stop needs armed gate
  assign enter_stop   = wr_sby & stop_bit & ~halt_bit & ~pend_any &
                        (unlock_q == MSC_UL_ARMED) & (mode_q == MSC_RUN);
  wire       wake_now = (mode_q == MSC_HALT) ? halt_wake :
                        (mode_q == MSC_STOP) ? stop_wake : 1'b0;
  // R14 maskable wake with master enable clear
  wire       no_serv  = wake_now & ~i_nmi_request & ~i_wdt_request & ~i_master_irq_enable;

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      MSC_RUN:
        if (enter_stop)
          mode_d = MSC_STOP;
        // R10 halt entry
        else if (req_halt)
          mode_d = MSC_HALT;
      // R20 halt bit clears next clock; R11 halt exit
      MSC_HALT:
        if (halt_wake)
          mode_d = MSC_RUN;
      // R9 stop exit
      MSC_STOP:
        if (stop_wake)
          mode_d = MSC_RUN;
      default:
        mode_d = MSC_RUN;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // R7 reset disarms gate
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q    <= MSC_RUN;
      unlock_q  <= MSC_UL_IDLE;
      wake_ns_q <= 1'b0;
    end
    else
    begin
      mode_q    <= mode_d;
      unlock_q  <= unlock_d;
      wake_ns_q <= no_serv;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      blk0_q <= MSC_BLOCK_RESET;
      blk1_q <= MSC_BLOCK_RESET;
      blk2_q <= MSC_BLOCK_RESET;
      blk3_q <= MSC_BLOCK_RESET;
      blk4_q <= MSC_BLOCK_RESET;
    end
    else if (wr_en)
    begin
      if (sel_b0)
        blk0_q <= wbyte;
      else if (sel_b1)
        blk1_q <= wbyte;
      else if (sel_b2)
        blk2_q <= wbyte;
      else if (sel_b3)
        blk3_q <= wbyte;
      else if (sel_b4)
        blk4_q <= wbyte;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_prdata <= 32'h0000_0000;
    else if (rd_setup)
      o_prdata <= {24'h00_0000, rd_byte};
  end

  // ****************************************
  // outputs
  // ****************************************
  // R3 stop halts oscillators and all
  assign o_cpu_halt        = (mode_q != MSC_RUN);
  assign o_osc_stop        = (mode_q == MSC_STOP);
  assign o_periph_stop     = (mode_q == MSC_STOP);
  assign o_wake_no_service = wake_ns_q;

  // one gate per timer channel
  genvar g;
  generate
    for (g = 0; g < MSC_NUM_TIMERS; g = g + 1)
    begin : g_tmr
      // R15 timer off bits; R17 reset and clock stop; R18 writes blocked
      assign o_timer_rst[g]      = blk0_q[g];
      assign o_timer_clk_en[g]   = ~blk0_q[g] & (mode_q != MSC_STOP);
      assign o_timer_wr_block[g] = blk0_q[g];
    end
  endgenerate

  // R16 pwm off bit; R17 and R18 same gating
  assign o_pwm_rst         = blk1_q[0];
  assign o_pwm_clk_en      = ~blk1_q[0] & (mode_q != MSC_STOP);
  assign o_pwm_wr_block    = blk1_q[0];
  assign o_block_disable_2 = blk2_q;
  assign o_block_disable_3 = blk3_q;
  assign o_block_disable_4 = blk4_q;

endmodule

/* File: verif/msc_standby_checker.sv */
`timescale 1ns/100ps
// ****************
// mode checker
// ****************
module msc_standby_checker
  import msc_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [15:0] i_irq_enable,
  input wire logic [15:0] i_irq_request,
  input wire logic        i_nmi_request,
  input wire logic        i_wdt_request,
  input wire logic [31:0] o_prdata,
  input wire logic        o_cpu_halt,
  input wire logic        o_osc_stop,
  input wire logic        o_periph_stop,
  input wire logic [3:0]  o_timer_rst,
  input wire logic [3:0]  o_timer_clk_en,
  input wire logic [3:0]  o_timer_wr_block,
  input wire logic        o_pwm_rst,
  input wire logic        o_pwm_clk_en,
  input wire logic        o_pwm_wr_block
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire acc  = i_psel && i_penable;
  wire pend = |(i_irq_enable & i_irq_request);
  sequence s_sby(v);
    acc && i_pwrite && i_pstrb[0] && i_paddr == MSC_STANDBY_CONTROL_OFS && i_pwdata[1:0] == v;
  endsequence
  property p_halt_in;
    s_sby(2'b01) ##0 (!pend && !i_nmi_request && !i_wdt_request && !o_cpu_halt) |=> o_cpu_halt && !o_periph_stop;
  endproperty
  a_halt_in: assert property (p_halt_in) else $error("halt not entered");
  property p_pend;
    s_sby(2'b01) ##0 (pend && !o_cpu_halt) |=> !o_cpu_halt;
  endproperty
  a_pend: assert property (p_pend) else $error("halt entered while irq pending");
  property p_hwake;
    o_cpu_halt && !o_osc_stop && (i_nmi_request || i_wdt_request || pend) |=> !o_cpu_halt;
  endproperty
  a_hwake: assert property (p_hwake) else $error("halt not left on wake");
  property p_swake;
    o_osc_stop && (i_nmi_request || |(i_irq_enable[3:0] & i_irq_request[3:0])) |=> !o_osc_stop;
  endproperty
  a_swake: assert property (p_swake) else $error("stop not left on wake");
  property p_stop;
    o_osc_stop |-> o_cpu_halt && o_periph_stop && o_timer_clk_en == 4'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop outputs wrong");
  property p_tmr;
    o_timer_wr_block == o_timer_rst && (o_timer_rst & o_timer_clk_en) == 4'h0;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer gating wrong");
  property p_pwm;
    o_pwm_clk_en == (!o_pwm_rst && !o_osc_stop) && o_pwm_wr_block == o_pwm_rst;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm gating wrong");
  property p_rd;
    acc && !i_pwrite && i_paddr == MSC_STOP_UNLOCK_OFS |-> o_prdata == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("unlock read not zero");
endmodule

/* File: verif/msc_irq_model.sv */
`timescale 1ns/100ps
// ****************
// irq source model
// ****************
module msc_irq_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_en,
  input  wire logic [15:0] i_req,
  input  wire logic [1:0]  i_nw,
  output logic      [15:0] o_en,
  output logic      [15:0] o_req,
  output logic      [1:0]  o_nw
);
  always_ff @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      {o_en, o_req, o_nw} <= 34'h0;
    else
      {o_en, o_req, o_nw} <= {i_en, i_req, i_nw};
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
// ****************
// bench
// ****************
module tb_top import msc_pkg::*;;
  localparam logic [15:0] UL = MSC_STOP_UNLOCK_OFS, SB = MSC_STANDBY_CONTROL_OFS, B0 = MSC_BLOCK_DISABLE_0_OFS;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, master_irq_enable = 0, seen = 0, rerr = 0;
  logic [15:0] pad = 16'h0, en_s = 16'h0;
  logic [31:0] pwd = 32'h0, rdat = 32'h0;
  logic [1:0]  nw_s = 2'h0;
  wire  [31:0] prd;
  wire  [15:0] ien, ireq;
  wire  [1:0]  nw;
  wire         prdy, perr, halt, osc, pst, nosvc, prst, pclk, pwb;
  wire  [3:0]  trst, tclk, twb;
  wire  [7:0]  b2, b3, b4;
  wire  [31:0] mode = {29'h0, halt, osc, pst};
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #2.5 clk = ~clk;
  msc_irq_model msc_irq_model_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_en(en_s), .i_req(en_s), .i_nw(nw_s),
    .o_en(ien), .o_req(ireq), .o_nw(nw));
  msc_standby_ctrl msc_standby_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pad), .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(perr), .i_irq_enable(ien), .i_irq_request(ireq), .i_nmi_request(nw[1]), .i_wdt_request(nw[0]),
    .i_master_irq_enable(master_irq_enable), .o_cpu_halt(halt), .o_osc_stop(osc), .o_periph_stop(pst),
    .o_wake_no_service(nosvc), .o_timer_rst(trst), .o_timer_clk_en(tclk), .o_timer_wr_block(twb),
    .o_pwm_rst(prst), .o_pwm_clk_en(pclk), .o_pwm_wr_block(pwb), .o_block_disable_2(b2),
    .o_block_disable_3(b3), .o_block_disable_4(b4));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  // read data and error flag are taken at the edge where pready is seen high
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    pad <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic irq(input logic [15:0] e, input logic [1:0] n);
    en_s <= e;
    nw_s <= n;
    repeat (3) @(posedge clk);
  endtask
  task automatic results();
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (nosvc === 1'b1)
      seen <= 1'b1;
    if (cyc == 4000)
    begin
      bad_count++;
      results();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(mode, 32'h0);
    xfer(0, UL, 8'h0);
    chk(rdat, 32'h0);
    xfer(0, 16'hf0f0, 8'h0);
    chk(rdat, 32'h0);
    chk({31'h0, rerr}, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      xfer(0, B0 + 16'(i), 8'h0);
      chk(rdat, 32'h0);
    end
    xfer(1, B0, 8'h0f);
    chk({20'h0, trst, tclk, twb}, 32'hf0f);
    xfer(0, B0, 8'h0);
    chk(rdat, 32'h0f);
    xfer(1, B0, 8'h05);
    chk({20'h0, trst, tclk, twb}, 32'h5a5);
    xfer(1, B0, 8'h00);
    xfer(1, B0 + 16'h1, 8'h01);
    chk({28'h0, trst[0], prst, pclk, pwb}, 32'h5);
    for (int i = 0; i < 3; i++)
      xfer(1, B0 + 16'(i + 2), 8'(129 + i));
    chk({8'h0, b2, b3, b4}, 32'h818283);
    xfer(1, SB, 8'h01);
    chk(mode, 32'h4);
    irq(16'h0, 2'b01);
    chk(mode, 32'h0);
    irq(16'h0, 2'b00);
    master_irq_enable <= 1'b1;
    xfer(1, SB, 8'h01);
    irq(16'h0020, 2'b00);
    @(posedge clk);
    chk({mode[30:0], seen}, 32'h0);
    irq(16'h0, 2'b00);
    master_irq_enable <= 1'b0;
    xfer(1, SB, 8'h01);
    irq(16'h0020, 2'b00);
    @(posedge clk);
    chk({mode[30:0], seen}, 32'h1);
    xfer(1, SB, 8'h01);
    chk(mode, 32'h0);
    irq(16'h0, 2'b00);
    xfer(1, SB, 8'h03);
    chk(mode, 32'h0);
    xfer(1, SB, 8'h02);
    chk(mode, 32'h0);
    xfer(1, UL, 8'h57);
    xfer(0, B0, 8'h0);
    xfer(1, UL, 8'ha3);
    xfer(1, SB, 8'h02);
    chk(mode, 32'h7);
    irq(16'h0004, 2'b00);
    chk(mode, 32'h0);
    irq(16'h0, 2'b00);
    xfer(1, SB, 8'h02);
    chk(mode, 32'h0);
    xfer(1, UL, 8'h50);
    xfer(1, UL, 8'h33);
    xfer(1, UL, 8'ha0);
    xfer(1, SB, 8'h02);
    chk(mode, 32'h0);
    irq(16'h0100, 2'b00);
    xfer(1, UL, 8'h5c);
    xfer(1, UL, 8'hac);
    irq(16'h0, 2'b00);
    xfer(1, SB, 8'h02);
    chk(mode, 32'h0);
    xfer(1, UL, 8'h55);
    xfer(1, UL, 8'haa);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(1, SB, 8'h02);
    chk(mode, 32'h0);
    xfer(1, UL, 8'h5f);
    xfer(1, UL, 8'haf);
    xfer(1, SB, 8'h02);
    chk(mode, 32'h7);
    irq(16'h0, 2'b10);
    chk(mode, 32'h0);
    results();
  end
endmodule
bind msc_standby_ctrl msc_standby_checker msc_standby_checker_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .i_irq_enable(i_irq_enable), .i_irq_request(i_irq_request), .i_nmi_request(i_nmi_request),
  .i_wdt_request(i_wdt_request), .o_prdata(o_prdata), .o_cpu_halt(o_cpu_halt), .o_osc_stop(o_osc_stop),
  .o_periph_stop(o_periph_stop), .o_timer_rst(o_timer_rst), .o_timer_clk_en(o_timer_clk_en),
  .o_timer_wr_block(o_timer_wr_block), .o_pwm_rst(o_pwm_rst), .o_pwm_clk_en(o_pwm_clk_en),
  .o_pwm_wr_block(o_pwm_wr_block));
